// file: rtl/gato_ops.v
// global two-stage address translation command block with axi4-lite slave
`timescale 1ns/1ps
`include "gato_defs.vh"

// What this block does
// - A low-word write to a command register of an idle bank starts a translation and its outcome lands in the result register.
// - A low-word write to a command register keeps its address and context fields with the upper word zero; bits 11 to 8 are dropped.
// - A write to the high word of a command register does nothing and starts nothing.
// - The input address field sits in bits 63 to 12, or 31 to 12 in the older variant.
// - Bits 7 to 0 of the command pick the context bank for stage 1.
// - The privileged-write command walks both stages as a privileged write.
// - The unprivileged-read command walks both stages as an unprivileged read.
// - The unprivileged-write command walks both stages as an unprivileged write.
// - The security of the access picks the secure or non-secure command register.
// - A secure alias lets secure accesses reach the non-secure commands and status.
// - Command registers are write-only, 64 bits in the newer and 32 in the older version.
// - The command registers may be left out in the newer version.
// - Status is a 32-bit read-only register whose bits 31 to 1 are reserved.
// - With two security states the status has a secure and a non-secure copy.
// - Status bit 0 is 1 from a command until the result is written, else 0.
module gato_ops #(
  parameter ADDR_W   = 8,
  parameter ARCH_V2  = 1,
  parameter IMPL_CMD = 1,
  parameter TWO_SEC  = 1
) (
  input  wire              MCLK,
  input  wire              RST_B,
  input  wire [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire [2:0]        S_AXI_AWPROT,
  input  wire              S_AXI_AWVALID,
  output wire              S_AXI_AWREADY,
  input  wire [31:0]       S_AXI_WDATA,
  input  wire [3:0]        S_AXI_WSTRB,
  input  wire              S_AXI_WVALID,
  output wire              S_AXI_WREADY,
  output reg  [1:0]        S_AXI_BRESP,
  output reg               S_AXI_BVALID,
  input  wire              S_AXI_BREADY,
  input  wire [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire [2:0]        S_AXI_ARPROT,
  input  wire              S_AXI_ARVALID,
  output wire              S_AXI_ARREADY,
  output reg  [31:0]       S_AXI_RDATA,
  output reg  [1:0]        S_AXI_RRESP,
  output reg               S_AXI_RVALID,
  input  wire              S_AXI_RREADY,
  output reg               XLAT_REQ,
  output reg  [63:0]       XLAT_ADDR,
  output reg  [7:0]        XLAT_CTX,
  output reg               XLAT_PRIV,
  output reg               XLAT_WRITE,
  output reg               XLAT_SECURE,
  input  wire              XLAT_DONE,
  input  wire [63:0]       XLAT_RESULT,
  output wire              ACTIVE_NS,
  output wire              ACTIVE_S
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WALK = 1'b1;
  localparam FLD_MSB = (ARCH_V2 != 0) ? `GATO_CMD_V2_MSB : `GATO_CMD_V1_MSB;
  localparam FLD_W   = FLD_MSB - `GATO_CMD_ADDR_LSB + 1;

  // --------------------------------------------------------------------
  // write channel holding registers
  // --------------------------------------------------------------------
  reg  [ADDR_W-1:0] aw_addr_q;
  reg               aw_sec_q;
  reg               aw_full_q;
  reg  [31:0]       w_data_q;
  reg               w_full_q;
  reg  [31:0]       wmask;
  reg  [31:0]       wd;
  wire              wr_fire;
  integer           k;

  assign S_AXI_AWREADY = ~aw_full_q & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = ~w_full_q & ~S_AXI_BVALID;

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_addr_q <= {ADDR_W{1'b0}};
      aw_sec_q  <= 1'b0;
      aw_full_q <= 1'b0;
      w_data_q  <= 32'h0;
      w_full_q  <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_addr_q <= S_AXI_AWADDR;
        aw_sec_q  <= ~S_AXI_AWPROT[1];
        aw_full_q <= 1'b1;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_data_q <= S_AXI_WDATA & wmask;
        w_full_q <= 1'b1;
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // unstrobed byte lanes enter the command as zero
  always @* begin
    wmask = 32'h0;
    for (k = 0; k < 4; k = k + 1) begin
      wmask[k*8 +: 8] = {8{S_AXI_WSTRB[k]}};
    end
  end

  // --------------------------------------------------------------------
  // write decode
  // --------------------------------------------------------------------
  assign wr_fire = aw_full_q & w_full_q & ~S_AXI_BVALID;
  wire [5:0] w_off    = aw_addr_q[`GATO_ADDR_OFF_MSB:0];
  wire       w_alias  = aw_addr_q[`GATO_ADDR_ALIAS];
  wire       w_mapped = ~|aw_addr_q[ADDR_W-1:`GATO_ADDR_TOP_LSB];
  // secure access picks the secure bank unless it goes through the alias
  wire       w_bank   = (TWO_SEC != 0) & aw_sec_q & ~w_alias;
  reg        w_cmd;
  reg  [1:0] w_kind;

  always @* begin
    w_cmd  = 1'b0;
    w_kind = `GATO_KIND_PW;
    case (w_off)
      `GATO_OFF_PW_LO: begin
        w_cmd  = 1'b1;
        w_kind = `GATO_KIND_PW;
      end
      `GATO_OFF_UR_LO: begin
        w_cmd  = 1'b1;
        w_kind = `GATO_KIND_UR;
      end
      `GATO_OFF_UW_LO: begin
        w_cmd  = 1'b1;
        w_kind = `GATO_KIND_UW;
      end
      // high words fall through with no command
      default: begin
        w_cmd  = 1'b0;
        w_kind = `GATO_KIND_PW;
      end
    endcase
  end

  wire cmd_hit = wr_fire & w_mapped & w_cmd & (IMPL_CMD != 0);

  always @* begin
    wd = w_data_q;
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `GATO_RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= w_mapped ? `GATO_RESP_OKAY : `GATO_RESP_DECERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // per-bank command, progress and result state
  // --------------------------------------------------------------------
  reg [FLD_W-1:0] cmd_addr_q [0:1];
  reg [7:0]       cmd_ctx_q  [0:1];
  reg [1:0]       cmd_kind_q [0:1];
  reg [63:0]      res_q      [0:1];
  reg [1:0]       pend_q;
  reg [1:0]       act_q;
  reg             state_q;
  reg             cur_q;
  integer         b;

  // a command that meets an active bank is dropped to keep state sane
  wire            accept = cmd_hit & ~act_q[w_bank];
  wire            pick   = pend_q[`GATO_BANK_S];

  assign ACTIVE_NS = act_q[`GATO_BANK_NS];
  assign ACTIVE_S  = act_q[`GATO_BANK_S];

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      for (b = 0; b < 2; b = b + 1) begin
        cmd_addr_q[b] <= {FLD_W{1'b0}};
        cmd_ctx_q[b]  <= 8'h0;
        cmd_kind_q[b] <= `GATO_KIND_PW;
        res_q[b]      <= `GATO_RES_RST;
      end
      pend_q      <= 2'h0;
      act_q       <= {2{`GATO_STATUS_RST}};
      state_q     <= ST_IDLE;
      cur_q       <= `GATO_BANK_NS;
      XLAT_REQ    <= 1'b0;
      XLAT_ADDR   <= 64'h0;
      XLAT_CTX    <= 8'h0;
      XLAT_PRIV   <= 1'b0;
      XLAT_WRITE  <= 1'b0;
      XLAT_SECURE <= 1'b0;
    end else begin
      if (accept) begin
        // low word taken with the upper word zero; bits 11:8 dropped
        cmd_addr_q[w_bank] <= {{(FLD_W-20){1'b0}},
                               wd[`GATO_CMD_V1_MSB:`GATO_CMD_ADDR_LSB]};
        cmd_ctx_q[w_bank]  <= wd[`GATO_CMD_CTX_MSB:`GATO_CMD_CTX_LSB];
        cmd_kind_q[w_bank] <= w_kind;
        pend_q[w_bank]     <= 1'b1;
        act_q[w_bank]      <= 1'b1;
      end
      case (state_q)
        ST_IDLE: begin
          if (|pend_q) begin
            cur_q        <= pick;
            pend_q[pick] <= 1'b0;
            XLAT_REQ     <= 1'b1;
            XLAT_ADDR    <= {{(64-FLD_W-`GATO_CMD_ADDR_LSB){1'b0}},
                             cmd_addr_q[pick],
                             {`GATO_CMD_ADDR_LSB{1'b0}}};
            XLAT_CTX     <= cmd_ctx_q[pick];
            XLAT_PRIV    <= (cmd_kind_q[pick] == `GATO_KIND_PW);
            XLAT_WRITE   <= (cmd_kind_q[pick] != `GATO_KIND_UR);
            XLAT_SECURE  <= pick;
            state_q      <= ST_WALK;
          end
        end
        ST_WALK: begin
          if (XLAT_DONE) begin
            res_q[cur_q] <= XLAT_RESULT;
            act_q[cur_q] <= 1'b0;
            XLAT_REQ     <= 1'b0;
            state_q      <= ST_IDLE;
          end
        end
        default: begin
          state_q  <= ST_IDLE;
          XLAT_REQ <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------------
  wire [5:0] r_off    = S_AXI_ARADDR[`GATO_ADDR_OFF_MSB:0];
  wire       r_alias  = S_AXI_ARADDR[`GATO_ADDR_ALIAS];
  wire       r_mapped = ~|S_AXI_ARADDR[ADDR_W-1:`GATO_ADDR_TOP_LSB];
  wire       r_bank   = (TWO_SEC != 0) & ~S_AXI_ARPROT[1] & ~r_alias;
  reg [31:0] r_data;

  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  always @* begin
    case (r_off)
      // bits 31:1 read as zero
      `GATO_OFF_STATUS: r_data = {31'h0, act_q[r_bank]};
      `GATO_OFF_RES_LO: r_data = res_q[r_bank][31:0];
      `GATO_OFF_RES_HI: r_data = res_q[r_bank][63:32];
      // command registers are write-only and read as zero
      default:          r_data = 32'h0;
    endcase
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0;
      S_AXI_RRESP  <= `GATO_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= r_mapped ? r_data : 32'h0;
      S_AXI_RRESP  <= r_mapped ? `GATO_RESP_OKAY : `GATO_RESP_DECERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule // gato_ops

// file: common/gato_defs.vh
// register map, field layout and encodings of the address translation ops
`ifndef GATO_DEFS_VH
`define GATO_DEFS_VH

// ----------------------------------------------------------------------
// register offsets inside one 64-byte bank window
// ----------------------------------------------------------------------
`define GATO_OFF_PW_LO     6'h00
`define GATO_OFF_PW_HI     6'h04
`define GATO_OFF_UR_LO     6'h08
`define GATO_OFF_UR_HI     6'h0C
`define GATO_OFF_UW_LO     6'h10
`define GATO_OFF_UW_HI     6'h14
`define GATO_OFF_STATUS    6'h18
`define GATO_OFF_RES_LO    6'h20
`define GATO_OFF_RES_HI    6'h24

// ----------------------------------------------------------------------
// address decode fields
// ----------------------------------------------------------------------
`define GATO_ADDR_OFF_MSB  5
`define GATO_ADDR_ALIAS    6
`define GATO_ADDR_TOP_LSB  7

// ----------------------------------------------------------------------
// command word fields
// ----------------------------------------------------------------------
`define GATO_CMD_ADDR_LSB  12
`define GATO_CMD_V1_MSB    31
`define GATO_CMD_V2_MSB    63
`define GATO_CMD_CTX_MSB   7
`define GATO_CMD_CTX_LSB   0

// ----------------------------------------------------------------------
// command kinds and bank indices
// ----------------------------------------------------------------------
`define GATO_KIND_PW       2'h0
`define GATO_KIND_UR       2'h1
`define GATO_KIND_UW       2'h2
`define GATO_BANK_NS       1'h0
`define GATO_BANK_S        1'h1

// ----------------------------------------------------------------------
// bus answers and reset values
// ----------------------------------------------------------------------
`define GATO_RESP_OKAY     2'h0
`define GATO_RESP_DECERR   2'h3
`define GATO_STATUS_RST    1'h0
`define GATO_RES_RST       64'h0

`endif

// file: test/gato_ops_properties.sv
// port assertions for the translation command block
`timescale 1ns/1ps
module gato_ops_props #(
  parameter ADDR_W = 8
) (
  input wire              MCLK,
  input wire              RST_B,
  input wire [ADDR_W-1:0] S_AXI_AWADDR,
  input wire [2:0]        S_AXI_AWPROT,
  input wire              S_AXI_AWVALID,
  input wire              S_AXI_AWREADY,
  input wire              S_AXI_WVALID,
  input wire              S_AXI_WREADY,
  input wire [1:0]        S_AXI_BRESP,
  input wire              S_AXI_BVALID,
  input wire              XLAT_REQ,
  input wire [63:0]       XLAT_ADDR,
  input wire              XLAT_SECURE,
  input wire              XLAT_DONE,
  input wire              ACTIVE_NS,
  input wire              ACTIVE_S
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  wire both = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  wire ns_w = both && !S_AXI_AWADDR[7] && (S_AXI_AWPROT[1] || S_AXI_AWADDR[6]);
  wire idle = !ACTIVE_NS && !ACTIVE_S;
  sequence s_ns_low;
    ns_w && idle && S_AXI_AWADDR[5:0] inside {6'h00, 6'h08, 6'h10};
  endsequence
  sequence s_ns_walk;
    ACTIVE_NS ##1 (XLAT_REQ && !XLAT_SECURE);
  endsequence
  a_cmd_start: assert property (s_ns_low |=> ##1 s_ns_walk)
    else $error("command write started no walk");
  a_high_ignored: assert property (
      ns_w && idle && S_AXI_AWADDR[5:0] == 6'h04 |=> ##1 !ACTIVE_NS)
    else $error("high word write started a walk");
  a_unmapped_err: assert property (
      both && S_AXI_AWADDR[7] |=> ##1 S_AXI_BVALID && S_AXI_BRESP == 2'h3)
    else $error("unmapped write not refused");
  a_addr_field: assert property (
      XLAT_REQ |-> XLAT_ADDR[11:0] == 12'h0 && XLAT_ADDR[63:32] == 32'h0)
    else $error("walk address has stray bits");
  a_req_stable: assert property (
      XLAT_REQ && !XLAT_DONE |=> XLAT_REQ && $stable(XLAT_ADDR))
    else $error("walk request changed early");
  a_req_drop: assert property (XLAT_REQ && XLAT_DONE |=> !XLAT_REQ)
    else $error("walk request held after done");
  a_active_ns: assert property (XLAT_REQ && !XLAT_SECURE |-> ACTIVE_NS)
    else $error("status low during walk");
  a_active_clr: assert property (
      XLAT_REQ && XLAT_SECURE && XLAT_DONE |=> !ACTIVE_S)
    else $error("secure status not cleared");
endmodule // gato_ops_props

bind gato_ops gato_ops_props #(.ADDR_W(ADDR_W)) i_gato_ops_props (
  .MCLK, .RST_B, .S_AXI_AWADDR, .S_AXI_AWPROT, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .XLAT_REQ,
  .XLAT_ADDR, .XLAT_SECURE, .XLAT_DONE, .ACTIVE_NS, .ACTIVE_S);

// file: test/gato_ops_bench.sv
// self-checking bench for the translation command block
`timescale 1ns/1ps
module gato_ops_bench;
  logic        clk = 0, rst_b = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic        done = 0;
  logic [7:0]  ad = 0;
  logic [2:0]  pr = 0;
  logic [31:0] wd = 0, seed = 32'hE;
  logic [63:0] res = 0;
  wire         awr, wr, bv, arr, rv, req, xpriv, xwr, xsec, act_ns, act_s;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [63:0] xaddr;
  wire  [7:0]  xctx;
  int          errors = 0, compares = 0;
  always #12.5 clk = ~clk;
  gato_ops i_gato_ops (
    .MCLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(ad), .S_AXI_AWPROT(pr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ad), .S_AXI_ARPROT(pr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .XLAT_REQ(req), .XLAT_ADDR(xaddr),
    .XLAT_CTX(xctx), .XLAT_PRIV(xpriv), .XLAT_WRITE(xwr), .XLAT_SECURE(xsec),
    .XLAT_DONE(done), .XLAT_RESULT(res), .ACTIVE_NS(act_ns),
    .ACTIVE_S(act_s));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    errors += int'(got !== exp);
    if (got !== exp) $display("mismatch at %0t: got %h, expected %h",
                              $time, got, exp);
  endtask
  task automatic final_report();
    $display("compares %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic hang();
    errors++;
    final_report();
  endtask
  // one register access; address and prot are shared by both channels
  task automatic bus(input logic w, input logic [7:0] a, input logic [2:0] p,
                     input logic [31:0] d, input logic [31:0] exp);
    int n;
    logic ta, tw, tr, tb;
    logic [1:0] gresp;
    logic [31:0] gdata;
    @(posedge clk);
    ad <= a;
    pr <= p;
    wd <= d;
    awv <= w;
    wv <= w;
    br <= w;
    arv <= !w;
    rr <= !w;
    tb = 0;
    gresp = 0;
    gdata = 0;
    // readies are settled mid-cycle; a handshake completes at the next edge
    for (n = 0; n < 40 && !tb; n++) begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr;
      tr = arv && arr;
      tb = w ? bv : rv;
      gresp = w ? bresp : rresp;
      gdata = rdata;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (tr) arv <= 0;
    end
    if (!tb) hang();
    chk(gresp, a[7] ? 2'h3 : 2'h0);
    if (!w) chk(gdata, exp);
    br <= 0;
    rr <= 0;
  endtask
  initial begin
    logic [31:0] d;
    logic [7:0]  base;
    logic [2:0]  p, s, k;
    int          n;
    repeat (16) @(posedge clk);
    rst_b <= 1;
    bus(0, 8'h18, 3'h2, 0, 0);
    bus(0, 8'h00, 3'h2, 0, 0);
    bus(1, 8'h80, 3'h2, rnd(), 0);
    bus(0, 8'h80, 3'h2, 0, 0);
    bus(1, 8'h04, 3'h2, rnd(), 0);
    repeat (6) @(posedge clk);
    chk(req, 0);
    $display("test reset and refusals done");
    // bank paths: non-secure, secure, secure alias to non-secure
    for (s = 0; s < 3; s++) begin
      for (k = 0; k < 3; k++) begin
        base = {1'b0, s == 3'h2, 6'h0};
        p = (s == 3'h0) ? 3'h2 : 3'h0;
        d = (s + k == 0) ? 32'hFFFFFFFF : rnd();
        res = {rnd(), rnd()};
        bus(1, base | {2'h0, k, 3'h0}, p, d, 0);
        for (n = 0; n < 30 && !req; n++) @(posedge clk);
        if (n == 30) hang();
        chk(xaddr, {32'h0, d[31:12], 12'h0});
        chk(xctx, d[7:0]);
        chk(xpriv, k == 3'h0);
        chk(xwr, k != 3'h1);
        chk(xsec, s == 3'h1);
        bus(0, base | 8'h18, p, 0, 1);
        bus(0, 8'h18, (s == 3'h1) ? 3'h2 : 3'h0, 0, 0);
        done <= 1;
        @(posedge clk);
        done <= 0;
        bus(0, base | 8'h20, p, 0, res[31:0]);
        bus(0, base | 8'h24, p, 0, res[63:32]);
        bus(0, base | 8'h18, p, 0, 0);
      end
      $display("test bank path %0d done", s);
    end
    final_report();
  end
endmodule // gato_ops_bench
